// *** rtl/cmds_regs.vh ***
// constants for the master diagnostic status block
//
// How it works
// - the cycle counter goes up by exactly one each time a master cycle completes.
// - the box error count gives how many attached boxes have a nonzero box status word.
// - the diagnostic change flag goes to 1 when stored diagnostic data changed and stays 0 while it is unchanged.
// - the first global status word codes the master state as run 0, reset 1, offline 2 and stop 3.
// - the second global status word holds the receive error count low and the transmit error count high.
// - bit 0 of the third global status word shows bus-off and bit 1 shows the error warning limit.
// - bits 2, 3 and 4 of the third word flag receive, high-priority and low-priority transmit queue overflow.
// - bit 5 of the third word flags a transmission failure and bits 6 to 14 stay reserved.
// - bit 15 of the third word inverts on every sync message sent; two sent in one master cycle cancel in the snapshot.
// - the fourth word and a separate output both give the bus load in percent.
// - the failed-cycle counter goes up by one when a host task cycle starts while the bus cycle is unfinished.
// - node codes are 0 no error, 1 deactivated, 2 not found, 4 startup syntax, 5 startup mismatch, 8 starting.
// - node codes are 11 bus-off, 12 pre-operational, 13 severe fault, 14 toggle, 20 short, 22 missing, 23 partial.
// - node codes are 128 receive data partial, 129 pre-operational and 130 stopped.
// - the terminal-bus indicator is off when absent, on when idle, and flashes during traffic.
`ifndef CMDS_REGS_VH
`define CMDS_REGS_VH

// sizes
`define CMDS_NNODE        4
`define CMDS_NCOND        15

// apb byte addresses
`define CMDS_OFF_STATE    8'h00
`define CMDS_OFF_ERRCNT   8'h04
`define CMDS_OFF_COND     8'h08
`define CMDS_OFF_UTIL     8'h0c
`define CMDS_OFF_CYCLE    8'h10
`define CMDS_OFF_BOXERR   8'h14
`define CMDS_OFF_FAILED   8'h18
`define CMDS_OFF_DIAG     8'h1c
`define CMDS_OFF_CLEAR    8'h20
`define CMDS_OFF_NODES    8'h24

// master operating states
`define CMDS_ST_RUN       2'h0
`define CMDS_ST_RESET     2'h1
`define CMDS_ST_OFFLINE   2'h2
`define CMDS_ST_STOP      2'h3

// condition word bit positions
`define CMDS_B_BUSOFF     0
`define CMDS_B_WARN       1
`define CMDS_B_RXQ        2
`define CMDS_B_TXQ_HI     3
`define CMDS_B_TXQ_LO     4
`define CMDS_B_SENDERR    5
`define CMDS_B_SYNC       15

// node condition input positions
`define CMDS_C_DEACT      0
`define CMDS_C_NOTFOUND   1
`define CMDS_C_SDOSYN     2
`define CMDS_C_SDOMIS     3
`define CMDS_C_START      4
`define CMDS_C_BUSOFF     5
`define CMDS_C_PREOPERR   6
`define CMDS_C_SEVERE     7
`define CMDS_C_TOGGLE     8
`define CMDS_C_TXSHORT    9
`define CMDS_C_TXMISS     10
`define CMDS_C_TXPART     11
`define CMDS_C_RXPART     12
`define CMDS_C_PREOP      13
`define CMDS_C_STOPPED    14

// node status codes
`define CMDS_NC_OK        8'h00
`define CMDS_NC_DEACT     8'h01
`define CMDS_NC_NOTFOUND  8'h02
`define CMDS_NC_SDOSYN    8'h04
`define CMDS_NC_SDOMIS    8'h05
`define CMDS_NC_START     8'h08
`define CMDS_NC_BUSOFF    8'h0b
`define CMDS_NC_PREOPERR  8'h0c
`define CMDS_NC_SEVERE    8'h0d
`define CMDS_NC_TOGGLE    8'h0e
`define CMDS_NC_TXSHORT   8'h14
`define CMDS_NC_TXMISS    8'h16
`define CMDS_NC_TXPART    8'h17
`define CMDS_NC_RXPART    8'h80
`define CMDS_NC_PREOP     8'h81
`define CMDS_NC_STOPPED   8'h82

// timing: indicator flash half period
`define CMDS_CLK_KHZ      24'd125000
`define CMDS_FLASH_HALF_MS 24'd100
`define CMDS_FLASH_CYC    (`CMDS_FLASH_HALF_MS * `CMDS_CLK_KHZ)

`endif

// *** rtl/cmds_node_code.v ***
// per-node status code encoder
`timescale 1ns/1ps
`default_nettype none
`include "cmds_regs.vh"

module cmds_node_code (
   input  wire [`CMDS_NCOND-1:0] i_cond,
   output reg  [7:0]             o_code
);

   // fixed priority: the most severe condition wins, so a dead node never looks merely partial
   always @* begin
      if (i_cond[`CMDS_C_DEACT])
         o_code = `CMDS_NC_DEACT;
      else if (i_cond[`CMDS_C_NOTFOUND])
         o_code = `CMDS_NC_NOTFOUND;
      else if (i_cond[`CMDS_C_SDOSYN])
         o_code = `CMDS_NC_SDOSYN;
      else if (i_cond[`CMDS_C_SDOMIS])
         o_code = `CMDS_NC_SDOMIS;
      else if (i_cond[`CMDS_C_START])
         o_code = `CMDS_NC_START;
      else if (i_cond[`CMDS_C_BUSOFF])
         o_code = `CMDS_NC_BUSOFF;
      else if (i_cond[`CMDS_C_SEVERE])
         o_code = `CMDS_NC_SEVERE;
      else if (i_cond[`CMDS_C_TOGGLE])
         o_code = `CMDS_NC_TOGGLE;
      else if (i_cond[`CMDS_C_PREOPERR])
         o_code = `CMDS_NC_PREOPERR;
      else if (i_cond[`CMDS_C_TXSHORT])
         o_code = `CMDS_NC_TXSHORT;
      else if (i_cond[`CMDS_C_TXMISS])
         o_code = `CMDS_NC_TXMISS;
      else if (i_cond[`CMDS_C_TXPART])
         o_code = `CMDS_NC_TXPART;
      else if (i_cond[`CMDS_C_RXPART])
         o_code = `CMDS_NC_RXPART;
      else if (i_cond[`CMDS_C_PREOP])
         o_code = `CMDS_NC_PREOP;
      else if (i_cond[`CMDS_C_STOPPED])
         o_code = `CMDS_NC_STOPPED;
      else
         o_code = `CMDS_NC_OK;
   end

endmodule
`default_nettype wire

// *** rtl/cmds_diag_status.v ***
// can master diagnostic status block with apb register access
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "cmds_regs.vh"

module cmds_diag_status #(
   parameter [23:0] FLASH_HALF_CYC = `CMDS_FLASH_CYC
) (
   input  wire                              i_mclk,
   input  wire                              i_rst,
   // apb slave
   input  wire                              i_psel,
   input  wire                              i_penable,
   input  wire                              i_pwrite,
   input  wire [7:0]                        i_paddr,
   input  wire [31:0]                       i_pwdata,
   input  wire [3:0]                        i_pstrb,
   output reg  [31:0]                       o_prdata,
   output reg                               o_pready,
   output reg                               o_pslverr,
   // master cycle events
   input  wire                              i_cycle_done,
   input  wire                              i_task_start,
   input  wire                              i_bus_cycle_busy,
   input  wire [1:0]                        i_op_state,
   // can controller status
   input  wire [7:0]                        i_rx_err_cnt,
   input  wire [7:0]                        i_tx_err_cnt,
   input  wire                              i_bus_off,
   input  wire                              i_warn_limit,
   input  wire                              i_rxq_ovf,
   input  wire                              i_txq_hi_ovf,
   input  wire                              i_txq_lo_ovf,
   input  wire                              i_send_err,
   input  wire                              i_sync_sent,
   input  wire [6:0]                        i_bus_load,
   // per-box and per-node state
   input  wire [`CMDS_NNODE-1:0]            i_box_status_nz,
   input  wire [`CMDS_NNODE*`CMDS_NCOND-1:0] i_node_cond,
   // terminal bus pins
   input  wire                              i_tbus_present,
   input  wire                              i_tbus_traffic,
   // outputs
   output reg  [6:0]                        o_bus_load_percent,
   output reg                               o_diag_change,
   output reg                               o_link_led
);

   // live state, updated as events arrive
   // counters are 16 bits and wrap; the host works with differences, so a wrap is harmless
   reg  [15:0] cycle_cnt_r;
   reg  [15:0] cycle_cnt_nxt;
   reg  [15:0] failed_cnt_r;
   reg  [15:0] failed_cnt_nxt;
   reg  [3:0]  sticky_r;
   reg  [3:0]  sticky_nxt;
   reg         sync_tgl_r;
   // snapshot seen by the host
   reg  [1:0]  snap_state_r;
   reg  [15:0] snap_err_r;
   reg  [15:0] snap_cond_r;
   reg  [6:0]  snap_util_r;
   reg  [3:0]  snap_boxerr_r;
   reg  [15:0] snap_failed_r;
   reg  [`CMDS_NNODE*8-1:0] snap_nodes_r;
   reg         diag_nxt;
   // combinational helpers
   wire [`CMDS_NNODE*8-1:0] node_code_w;
   reg  [3:0]  box_cnt;
   reg  [15:0] cond_now;
   reg         diag_changed;
   integer     k;

   // one encoder per node
   genvar g;
   generate
      for (g = 0; g < `CMDS_NNODE; g = g + 1) begin : g_node
         cmds_node_code u_code (
            .i_cond (i_node_cond[g*`CMDS_NCOND +: `CMDS_NCOND]),
            .o_code (node_code_w[g*8 +: 8])
         );
      end
   endgenerate

   // apb phases: a completed transfer is the access cycle in which pready is seen
   wire apb_done  = i_psel & i_penable & o_pready;
   wire wr_done   = apb_done & i_pwrite;
   wire rd_done   = apb_done & ~i_pwrite;
   // the clear bits all sit in byte lane 0, so only that strobe is honoured
   wire clr_wr    = wr_done & (i_paddr == `CMDS_OFF_CLEAR) & i_pstrb[0];
   wire diag_rd   = rd_done & (i_paddr == `CMDS_OFF_DIAG);

   // count boxes whose status word is nonzero
   // this count is independent of the node codes, which come from another source
   always @* begin
      box_cnt = 4'h0;
      for (k = 0; k < `CMDS_NNODE; k = k + 1)
         box_cnt = box_cnt + {3'h0, i_box_status_nz[k]};
   end

   // condition word as it would be captured at this edge
   always @* begin
      cond_now                     = 16'h0000;
      cond_now[`CMDS_B_BUSOFF]     = i_bus_off;
      cond_now[`CMDS_B_WARN]       = i_warn_limit;
      cond_now[`CMDS_B_RXQ]        = sticky_nxt[0];
      cond_now[`CMDS_B_TXQ_HI]     = sticky_nxt[1];
      cond_now[`CMDS_B_TXQ_LO]     = sticky_nxt[2];
      cond_now[`CMDS_B_SENDERR]    = sticky_nxt[3];
      cond_now[`CMDS_B_SYNC]       = sync_tgl_r ^ i_sync_sent;
   end

   // diagnostic content: node codes, state and flag bits; counters and load are excluded
   // since they move every cycle and would keep the flag stuck at one
   always @* begin
      diag_changed = (node_code_w != snap_nodes_r) |
                     (i_op_state != snap_state_r) |
                     (cond_now[5:0] != snap_cond_r[5:0]);
   end

   // next values of the live counters and sticky flags
   always @* begin
      cycle_cnt_nxt  = cycle_cnt_r;
      failed_cnt_nxt = failed_cnt_r;
      if (i_cycle_done)
         cycle_cnt_nxt = cycle_cnt_r + 16'h0001;
      if (i_task_start & i_bus_cycle_busy)
         failed_cnt_nxt = failed_cnt_r + 16'h0001;
      // a new overflow in the clearing cycle survives: set beats clear
      sticky_nxt = sticky_r & ~({4{clr_wr}} & i_pwdata[`CMDS_B_SENDERR:`CMDS_B_RXQ]);
      sticky_nxt = sticky_nxt | {i_send_err, i_txq_lo_ovf, i_txq_hi_ovf, i_rxq_ovf};
      // the flag rises on a change seen at cycle end; a read of it drops it, but a new
      // change in that same cycle keeps it up
      diag_nxt = o_diag_change;
      if (diag_rd)
         diag_nxt = 1'b0;
      if (i_cycle_done & diag_changed)
         diag_nxt = 1'b1;
   end

   // live state registers
   always @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         cycle_cnt_r  <= 16'h0000;
         failed_cnt_r <= 16'h0000;
         sticky_r     <= 4'h0;
         sync_tgl_r   <= 1'b0;
         o_diag_change <= 1'b0;
      end else begin
         cycle_cnt_r  <= cycle_cnt_nxt;
         failed_cnt_r <= failed_cnt_nxt;
         sticky_r     <= sticky_nxt;
         // two sync messages inside one master cycle cancel in the snapshot: a known limit
         if (i_sync_sent)
            sync_tgl_r <= ~sync_tgl_r;
         o_diag_change <= diag_nxt;
      end
   end

   // snapshot: every host-visible word but the cycle counter, the change flag and the sticky flags is taken at the same
   // cycle end, so a read of those words never mixes values from two master cycles
   always @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         snap_state_r       <= `CMDS_ST_RESET;
         snap_err_r         <= 16'h0000;
         snap_cond_r        <= 16'h0000;
         snap_util_r        <= 7'h00;
         snap_boxerr_r      <= 4'h0;
         snap_failed_r      <= 16'h0000;
         snap_nodes_r       <= {`CMDS_NNODE*8{1'b0}};
         o_bus_load_percent <= 7'h00;
      end else if (i_cycle_done) begin
         snap_state_r       <= i_op_state;
         snap_err_r         <= {i_tx_err_cnt, i_rx_err_cnt};
         snap_cond_r        <= cond_now;
         snap_util_r        <= i_bus_load;
         snap_boxerr_r      <= box_cnt;
         snap_failed_r      <= failed_cnt_nxt;
         snap_nodes_r       <= node_code_w;
         // the load output moves with the snapshot so both views of it agree
         o_bus_load_percent <= i_bus_load;
      end
   end

   // register read decode; unmapped addresses answer with an error
   // the cycle counter, the change flag and the sticky flags at the clear address are read live, every other status word from the snapshot
   reg [31:0] rdata_nxt;
   reg        hit;
   always @* begin
      rdata_nxt = 32'h0000_0000;
      hit       = 1'b1;
      case (i_paddr)
         `CMDS_OFF_STATE:  rdata_nxt = {30'h0, snap_state_r};
         `CMDS_OFF_ERRCNT: rdata_nxt = {16'h0, snap_err_r};
         `CMDS_OFF_COND:   rdata_nxt = {16'h0, snap_cond_r};
         `CMDS_OFF_UTIL:   rdata_nxt = {25'h0, snap_util_r};
         `CMDS_OFF_CYCLE:  rdata_nxt = {16'h0, cycle_cnt_r};
         `CMDS_OFF_BOXERR: rdata_nxt = {28'h0, snap_boxerr_r};
         `CMDS_OFF_FAILED: rdata_nxt = {16'h0, snap_failed_r};
         `CMDS_OFF_DIAG:   rdata_nxt = {31'h0, o_diag_change};
         `CMDS_OFF_CLEAR:  rdata_nxt = {26'h0, sticky_r, 2'h0};
         `CMDS_OFF_NODES:  rdata_nxt = snap_nodes_r;
         default:          hit       = 1'b0;
      endcase
   end

   // apb answer: pready rises in the second access cycle, data and error with it;
   // one wait state keeps the read mux off the bus path
   always @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_pready  <= 1'b0;
         o_prdata  <= 32'h0000_0000;
         o_pslverr <= 1'b0;
      end else if (i_psel & i_penable & ~o_pready) begin
         o_pready  <= 1'b1;
         // a write gets no data back; its effect lands at the completing edge
         o_prdata  <= i_pwrite ? 32'h0000_0000 : rdata_nxt;
         o_pslverr <= ~hit;
      end else begin
         o_pready  <= 1'b0;
         o_prdata  <= 32'h0000_0000;
         o_pslverr <= 1'b0;
      end
   end

   // terminal bus pins cross in from outside: three stages, change accepted when
   // the second and third agree
   reg [2:0] pres_s_r;
   reg [2:0] traf_s_r;
   reg       pres_f_r;
   reg       traf_f_r;

   // stages reset low, matching an absent terminal bus, so no false change follows reset
   always @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         pres_s_r <= 3'h0;
         traf_s_r <= 3'h0;
         pres_f_r <= 1'b0;
         traf_f_r <= 1'b0;
      end else begin
         pres_s_r <= {pres_s_r[1:0], i_tbus_present};
         traf_s_r <= {traf_s_r[1:0], i_tbus_traffic};
         if (pres_s_r[1] == pres_s_r[2])
            pres_f_r <= pres_s_r[2];
         if (traf_s_r[1] == traf_s_r[2])
            traf_f_r <= traf_s_r[2];
      end
   end

   // indicator state machine
   localparam [1:0] LED_OFF   = 2'h0;
   localparam [1:0] LED_ON    = 2'h1;
   localparam [1:0] LED_FLASH = 2'h2;

   // state register, its next value and the half-period timer of the flash
   reg [1:0]  led_st_r;
   reg [1:0]  led_st_nxt;
   reg [23:0] flash_cnt_r;

   always @* begin
      case (led_st_r)
         LED_OFF:   led_st_nxt = pres_f_r ? (traf_f_r ? LED_FLASH : LED_ON) : LED_OFF;
         LED_ON:    led_st_nxt = pres_f_r ? (traf_f_r ? LED_FLASH : LED_ON) : LED_OFF;
         LED_FLASH: led_st_nxt = pres_f_r ? (traf_f_r ? LED_FLASH : LED_ON) : LED_OFF;
         default:   led_st_nxt = LED_OFF;
      endcase
   end

   // the flash timer only runs during traffic; a burst shorter than one half period gives no blink
   always @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         led_st_r    <= LED_OFF;
         flash_cnt_r <= 24'h000000;
         o_link_led  <= 1'b0;
      end else begin
         // outputs decode the next state, so the led moves at the same edge as the state
         led_st_r <= led_st_nxt;
         case (led_st_nxt)
            LED_OFF: begin
               flash_cnt_r <= 24'h000000;
               o_link_led  <= 1'b0;
            end
            LED_ON: begin
               flash_cnt_r <= 24'h000000;
               o_link_led  <= 1'b1;
            end
            LED_FLASH: begin
               // the count restarts on entry, so every blink lasts a full half period
               if (flash_cnt_r >= FLASH_HALF_CYC - 24'h000001) begin
                  flash_cnt_r <= 24'h000000;
                  o_link_led  <= ~o_link_led;
               end else begin
                  flash_cnt_r <= flash_cnt_r + 24'h000001;
               end
            end
            default: begin
               flash_cnt_r <= 24'h000000;
               o_link_led  <= 1'b0;
            end
         endcase
      end
   end

endmodule
`default_nettype wire

// *** tb/cmds_diag_status_assertions.sv ***
// port-level checks for the diagnostic status block
`timescale 1ns/1ps
`default_nettype none
`include "cmds_regs.vh"

module cmds_diag_status_assertions #(
   parameter [23:0] FLASH_HALF_CYC = `CMDS_FLASH_CYC
) (
   input wire logic        i_mclk,
   input wire logic        i_rst,
   input wire logic        i_psel,
   input wire logic        i_penable,
   input wire logic [7:0]  i_paddr,
   input wire logic [31:0] o_prdata,
   input wire logic        o_pready,
   input wire logic        o_pslverr,
   input wire logic        i_cycle_done,
   input wire logic [6:0]  i_bus_load,
   input wire logic        i_tbus_present,
   input wire logic        i_tbus_traffic,
   input wire logic [6:0]  o_bus_load_percent,
   input wire logic        o_diag_change,
   input wire logic        o_link_led
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);

   // request sitting in its first access cycle
   sequence s_apb_wait;
      i_psel && i_penable && !o_pready;
   endsequence
   // pins held long enough to cross the three-stage synchroniser and the led stage
   sequence s_tbus_absent;
      !i_tbus_present [*8];
   endsequence
   sequence s_tbus_idle;
      (i_tbus_present && !i_tbus_traffic) [*8];
   endsequence

   a_pready_one_wait: assert property (s_apb_wait |=> o_pready)
      else $error("ready missed the single wait state");
   a_pready_pulse: assert property (o_pready |=> !o_pready)
      else $error("ready stood longer than one cycle");
   a_rdata_idle_zero: assert property (!o_pready |-> o_prdata == 32'h0)
      else $error("read data nonzero outside ready");
   a_slverr_unmapped: assert property ((o_pready && i_paddr[1:0] == 2'b00) |-> o_pslverr == (i_paddr > 8'h24))
      else $error("error response does not match address map");
   a_load_follows: assert property (i_cycle_done |=> o_bus_load_percent == $past(i_bus_load))
      else $error("bus load not taken at cycle end");
   a_load_holds: assert property (!i_cycle_done |=> $stable(o_bus_load_percent))
      else $error("bus load moved between cycle ends");
   a_diag_set_cause: assert property ($rose(o_diag_change) |-> $past(i_cycle_done))
      else $error("change flag rose without a cycle end");
   a_diag_level_holds: assert property ((o_diag_change && !(i_psel && i_paddr == 8'h1c)) |=> o_diag_change)
      else $error("change flag dropped without a read");
   a_led_off_absent: assert property (s_tbus_absent |-> !o_link_led)
      else $error("indicator lit with no terminal bus");
   a_led_on_idle: assert property (s_tbus_idle |-> o_link_led)
      else $error("indicator dark on an idle terminal bus");
endmodule

bind cmds_diag_status cmds_diag_status_assertions #(.FLASH_HALF_CYC(FLASH_HALF_CYC)) u_chk (
   .i_mclk             (i_mclk),
   .i_rst              (i_rst),
   .i_psel             (i_psel),
   .i_penable          (i_penable),
   .i_paddr            (i_paddr),
   .o_prdata           (o_prdata),
   .o_pready           (o_pready),
   .o_pslverr          (o_pslverr),
   .i_cycle_done       (i_cycle_done),
   .i_bus_load         (i_bus_load),
   .i_tbus_present     (i_tbus_present),
   .i_tbus_traffic     (i_tbus_traffic),
   .o_bus_load_percent (o_bus_load_percent),
   .o_diag_change      (o_diag_change),
   .o_link_led         (o_link_led)
);
`default_nettype wire

// *** tb/cmds_node_model.sv ***
// model of the slave nodes: each node reports one condition or none
`timescale 1ns/1ps
`default_nettype none

module cmds_node_model (
   input  wire logic [15:0] i_fault_sel,
   output wire logic [59:0] o_node_cond,
   output wire logic [3:0]  o_box_nz
);
   // selector 4'hf means a healthy node; a faulty one also shows a nonzero box word
   for (genvar n = 0; n < 4; n++) begin : g_node
      assign o_node_cond[n*15 +: 15] = (i_fault_sel[n*4 +: 4] == 4'hf) ? 15'h0 : 15'h1 << i_fault_sel[n*4 +: 4];
      assign o_box_nz[n]             = (i_fault_sel[n*4 +: 4] != 4'hf);
   end
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// self-checking bench for the diagnostic status block
`timescale 1ns/1ps
`default_nettype none

module tb;
   logic        i_mclk = 0;
   logic        i_rst = 1;
   logic        i_psel = 0, i_penable = 0, i_pwrite = 0;
   logic [7:0]  i_paddr = 8'h00;
   logic [31:0] i_pwdata = 32'h0;
   logic [1:0]  i_op_state = 2'h0;
   logic [7:0]  i_rx_err_cnt = 8'h00, i_tx_err_cnt = 8'h00;
   logic [6:0]  i_bus_load = 7'h00;
   logic [6:0]  ev = 7'h00;
   logic        i_bus_cycle_busy = 0, i_bus_off = 0, i_warn_limit = 0;
   logic        i_tbus_present = 0, i_tbus_traffic = 0;
   logic [15:0] fault_sel = 16'hffff;
   wire  [59:0] node_cond;
   wire  [3:0]  box_nz;
   wire  [31:0] o_prdata;
   wire  [6:0]  o_bus_load_percent;
   wire         o_pready, o_pslverr, o_diag_change, o_link_led;
   logic [31:0] q;
   logic        e;
   int          err_total = 0, compares = 0, cycles = 0;
   logic [7:0]  codes [15] = '{8'h01, 8'h02, 8'h04, 8'h05, 8'h08, 8'h0b, 8'h0c, 8'h0d,
                               8'h0e, 8'h14, 8'h16, 8'h17, 8'h80, 8'h81, 8'h82};

   always #4 i_mclk = ~i_mclk;

   // ev bits: 0 cycle end, 1 task start, 2..5 overflow and send error, 6 sync sent
   cmds_diag_status #(.FLASH_HALF_CYC(24'd4)) DUT (
      .i_mclk(i_mclk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
      .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(4'hf), .o_prdata(o_prdata), .o_pready(o_pready),
      .o_pslverr(o_pslverr), .i_cycle_done(ev[0]), .i_task_start(ev[1]), .i_bus_cycle_busy(i_bus_cycle_busy),
      .i_op_state(i_op_state), .i_rx_err_cnt(i_rx_err_cnt), .i_tx_err_cnt(i_tx_err_cnt), .i_bus_off(i_bus_off),
      .i_warn_limit(i_warn_limit), .i_rxq_ovf(ev[2]), .i_txq_hi_ovf(ev[3]), .i_txq_lo_ovf(ev[4]),
      .i_send_err(ev[5]), .i_sync_sent(ev[6]), .i_bus_load(i_bus_load), .i_box_status_nz(box_nz),
      .i_node_cond(node_cond), .i_tbus_present(i_tbus_present), .i_tbus_traffic(i_tbus_traffic),
      .o_bus_load_percent(o_bus_load_percent), .o_diag_change(o_diag_change), .o_link_led(o_link_led));

   cmds_node_model u_nodes (.i_fault_sel(fault_sel), .o_node_cond(node_cond), .o_box_nz(box_nz));

   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one apb transfer; waits on ready rather than assuming the wait-state count
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_mclk);
      i_psel <= 1;
      i_pwrite <= wr;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_mclk);
      i_penable <= 1;
      do begin
         @(posedge i_mclk);
      end while (o_pready !== 1'b1);
      q = o_prdata;
      e = o_pslverr;
      i_psel <= 0;
      i_penable <= 0;
   endtask

   task rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(q, exp);
   endtask

   task pulse(input logic [6:0] m);
      @(posedge i_mclk);
      ev <= m;
      @(posedge i_mclk);
      ev <= 7'h00;
   endtask

   task t_regs;
      rd(8'h00, 32'h1);
      rd(8'h10, 32'h0);
      rd(8'h18, 32'h0);
      apb(1'b1, 8'h00, 32'h3);
      rd(8'h00, 32'h1);
      apb(1'b0, 8'h40, 32'h0);
      chk({31'h0, e}, 32'h1);
      chk(q, 32'h0);
      $display("t_regs done");
   endtask

   task t_state;
      for (int s = 0; s < 4; s++) begin
         i_op_state <= 2'(s);
         i_rx_err_cnt <= 8'h10 + 8'(s);
         i_tx_err_cnt <= 8'h80 + 8'(s);
         i_bus_load <= 7'(33 * s);
         pulse(7'h01);
         rd(8'h00, 32'(s));
         rd(8'h04, {16'h0, 8'h80 + 8'(s), 8'h10 + 8'(s)});
         rd(8'h0c, 32'(33 * s));
         chk({25'h0, o_bus_load_percent}, 32'(33 * s));
         rd(8'h10, 32'(s + 1));
      end
      @(posedge i_mclk);
      ev <= 7'h01;
      @(posedge i_mclk);
      @(posedge i_mclk);
      ev <= 7'h00;
      rd(8'h10, 32'h6);
      $display("t_state done");
   endtask

   task t_cond;
      i_bus_off <= 1;
      i_warn_limit <= 1;
      pulse(7'h7c);
      pulse(7'h01);
      rd(8'h08, 32'h803f);
      rd(8'h20, 32'h3c);
      i_bus_off <= 0;
      i_warn_limit <= 0;
      pulse(7'h40);
      apb(1'b1, 8'h20, 32'h3c);
      pulse(7'h01);
      rd(8'h08, 32'h0);
      rd(8'h20, 32'h0);
      $display("t_cond done");
   endtask

   task t_nodes;
      logic [15:0] sel;
      for (int i = 0; i < 15; i++) begin
         sel = 16'hffff;
         sel[(i % 4) * 4 +: 4] = 4'(i);
         fault_sel <= sel;
         pulse(7'h01);
         rd(8'h24, {24'h0, codes[i]} << (8 * (i % 4)));
         rd(8'h14, 32'h1);
         chk({31'h0, o_diag_change}, 32'h1);
         rd(8'h1c, 32'h1);
         @(posedge i_mclk);
         chk({31'h0, o_diag_change}, 32'h0);
      end
      pulse(7'h01);
      rd(8'h1c, 32'h0);
      fault_sel <= 16'h90fc;
      pulse(7'h01);
      rd(8'h14, 32'h3);
      rd(8'h24, 32'h14010080);
      $display("t_nodes done");
   endtask

   task t_failed;
      i_bus_cycle_busy <= 1;
      pulse(7'h02);
      i_bus_cycle_busy <= 0;
      pulse(7'h02);
      pulse(7'h01);
      rd(8'h18, 32'h1);
      i_bus_cycle_busy <= 1;
      pulse(7'h03);
      i_bus_cycle_busy <= 0;
      rd(8'h18, 32'h2);
      $display("t_failed done");
   endtask

   // flash half period is 4 cycles here, so 32 cycles of traffic give about 8 toggles
   task t_led;
      int n;
      logic prev;
      n = 0;
      repeat (10) @(posedge i_mclk);
      chk({31'h0, o_link_led}, 32'h0);
      i_tbus_present <= 1;
      repeat (10) @(posedge i_mclk);
      chk({31'h0, o_link_led}, 32'h1);
      i_tbus_traffic <= 1;
      repeat (8) @(posedge i_mclk);
      prev = o_link_led;
      repeat (32) begin
         @(posedge i_mclk);
         if (o_link_led !== prev) n++;
         prev = o_link_led;
      end
      chk({31'h0, n >= 7 && n <= 9}, 32'h1);
      i_tbus_traffic <= 0;
      repeat (10) @(posedge i_mclk);
      chk({31'h0, o_link_led}, 32'h1);
      $display("t_led done");
   endtask

   task end_of_test;
      $display("compares=%0d err_total=%0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // hang guard: the whole run needs under a thousand cycles
   always @(posedge i_mclk) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         end_of_test;
      end
   end

   initial begin
      repeat (8) @(posedge i_mclk);
      i_rst <= 0;
      t_regs;
      t_state;
      t_cond;
      t_nodes;
      t_failed;
      t_led;
      end_of_test;
   end
endmodule
`default_nettype wire
